// [hdl/ccb_mem.sv]
// channel control block storage, one write port and one registered read port
module ccb_mem #(
  parameter int AW = 7
) (
  // clock
  input wire logic clk_in,
  // write port
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [31:0] wdata_in,
  // read port
  input wire logic [AW-1:0] raddr_in,
  output logic [31:0] rdata_out
);
  logic [31:0] mem_ff [2**AW];
  logic [31:0] rdata_ff;

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_ff[waddr_in] <= wdata_in;
    end
  end

  // contents are host parameters, so no reset is needed
  always_ff @(posedge clk_in) begin
    rdata_ff <= mem_ff[raddr_in];
  end

  assign rdata_out = rdata_ff;
endmodule : ccb_mem

// [hdl/chan_counter.sv]
// one counter channel: counts external edges or time base ticks into a two-phase wave
module chan_counter (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // configuration
  input wire logic load_in,
  input cwg_pkg::chan_cfg_t cfg_in,
  // count sources
  input wire logic ext_in,
  input wire logic [4:0] ticks_in,
  // waveform
  output logic wave_out
);
  import cwg_pkg::*;

  logic ext_prev_ff;
  logic wave_ff;
  logic [31:0] cnt_ff;
  logic step;
  logic run;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ext_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= ext_in;
    end
  end

  assign run = (cfg_in.mode == M_EXT) || (cfg_in.mode == M_TICK);

  always_comb begin
    case (cfg_in.mode)
      M_EXT: step = ext_in & ~ext_prev_ff;
      M_TICK: step = (cfg_in.base < 3'h5) ? ticks_in[cfg_in.base] : 1'b0;
      default: step = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !run) begin
      wave_ff <= 1'b0;
      cnt_ff <= 32'h0;
    end else if (load_in) begin
      wave_ff <= 1'b1;
      cnt_ff <= cfg_in.hi;
    end else if (step) begin
      if (cnt_ff <= 32'h1) begin
        wave_ff <= ~wave_ff;
        cnt_ff <= wave_ff ? cfg_in.lo : cfg_in.hi;
      end else begin
        cnt_ff <= cnt_ff - 32'h1;
      end
    end
  end

  half_flip_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (run && !load_in && step && cnt_ff == 32'h1) |=> (wave_ff != $past(wave_ff)))
    else $error("wave did not flip at end of phase");

  assign wave_out = wave_ff;
endmodule : chan_counter

// [hdl/cwg_defs.svh]
// offsets, status codes, bounds and timing constants of the waveform generator
`ifndef CWG_DEFS_SVH
`define CWG_DEFS_SVH

// channel control block word offsets
`define CCB_PARAM1_OFF 4'h4
`define CCB_PARAM2_OFF 4'h8

// command codes
`define CMD_DISABLE 8'h02
`define CMD_DIV16 8'h07
`define CMD_DIV32 8'h08
`define CMD_SQUARE 8'h09
`define CMD_PULSE 8'h0A

// status codes
`define ST_ACK 8'h01
`define ST_DIV_READY 8'h10
`define ST_BOUNDS 8'h20
`define ST_ALLOC 8'h21
`define ST_ACTIVE 8'h22
`define ST_PERIOD 8'h23
`define ST_BAD_CMD 8'h24

// divisor bounds
`define DIV16_MIN 32'h0000_0002
`define DIV32_LIMIT 32'h0001_0000

// timing
`define CLK_NS 50
`define TB0_NS 200
`define TB0_CYC ((`TB0_NS + `CLK_NS - 1) / `CLK_NS)
`define TB0_LOG2 2
`define TB_STEP_LOG2 4
`define TB_COUNT 5
`define PER_MIN_NS 400
`define PER_MAX_US 262140000
`define PW_MIN_NS 200
`define PW_MAX_US 131070000
`define ERR_PERIOD_US 13200
`define NS_TO_UNITS(x) (34'((x) / `TB0_NS))
`define US_TO_UNITS(x) (34'((64'(x) * 64'h3E8) / 64'(`TB0_NS)))
`define ERR_HALF_UNITS (32'(`US_TO_UNITS(`ERR_PERIOD_US) / 34'h2))
`define FLT_SCALE 48'h4C4B40

`endif

// [hdl/cwg_pkg.sv]
// types shared by the waveform generator modules
package cwg_pkg;
  typedef enum logic [1:0] {M_OFF, M_EXT, M_TICK, M_SLAVE} chan_mode_t;
  typedef struct packed {
    logic [7:0] code;
    logic [4:0] chan;
  } cmd_req_t;
  typedef struct packed {
    logic [7:0] code;
    logic [4:0] chan;
  } status_t;
  typedef struct packed {
    chan_mode_t mode;
    logic [2:0] base;
    logic [31:0] hi;
    logic [31:0] lo;
  } chan_cfg_t;
endpackage : cwg_pkg

// [hdl/wave_gen.sv]
// command-driven counter channels generating divider and period waveforms
`include "cwg_defs.svh"

//////////////////////////////////////////////////////////////////////////////
module wave_gen #(
  parameter int NUM_CH = 24
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // shared-memory channel control block port
  input wire logic host_we_in,
  input wire logic host_re_in,
  input wire logic [8:0] host_addr_in,
  input wire logic [31:0] host_wdata_in,
  output logic host_ready_out,
  output logic [31:0] host_rdata_out,
  output logic host_rvalid_out,
  // command port
  input wire logic cmd_valid_in,
  input cwg_pkg::cmd_req_t cmd_in,
  output logic cmd_ready_out,
  input wire logic irq_enable_in,
  input wire logic [2:0] irq_level_in,
  // status
  output cwg_pkg::status_t cmd_status_out,
  output logic cmd_status_valid_out,
  output cwg_pkg::status_t chan_status_out,
  output logic chan_status_valid_out,
  output logic cmd_irq_out,
  // channel pins
  input wire logic [NUM_CH-1:0] chan_clk_in,
  output logic [NUM_CH-1:0] chan_wave_out
);
  import cwg_pkg::*;

  initial begin
    if (NUM_CH < 2 || NUM_CH > 32 || NUM_CH % 2 != 0 || `TB0_CYC != (1 << `TB0_LOG2)) begin
      $error("wave_gen: unsupported parameters");
    end
  end

  localparam int PW = `TB0_LOG2 + `TB_STEP_LOG2 * (`TB_COUNT - 1);

  typedef enum {S_IDLE, S_RD1, S_RD2, S_EVAL} state_t;

  //////////////////////////////////////////////////////////////////////////////
  // float seconds to 200 ns units, saturating; negatives and denormals give zero
  function automatic logic [33:0] to_units(input logic [31:0] f);
    logic [47:0] p;
    logic [63:0] q;
    int e;
    p = 48'({1'b1, f[22:0]}) * `FLT_SCALE;
    q = {p, 16'h0};
    e = int'(f[30:23]) - 127;
    if (f[31] || f[30:23] == 8'h0 || e < -24) begin
      to_units = 34'h0;
    end else if (e > 39) begin
      to_units = '1;
    end else begin
      q = q >> (39 - e);
      to_units = (|q[63:34]) ? '1 : q[33:0];
    end
  endfunction : to_units

  // smallest time base whose scaled count fits a 16-bit counter
  function automatic logic [2:0] tb_pick(input logic [33:0] t);
    tb_pick = 3'h4;
    for (int k = 3; k >= 0; k--) begin
      if ((t >> (`TB_STEP_LOG2 * k)) < 34'h10000) begin
        tb_pick = 3'(k);
      end
    end
  endfunction : tb_pick

  // raise a zero count to one so a phase never stalls
  function automatic logic [31:0] at_least1(input logic [33:0] t);
    at_least1 = (t == 34'h0) ? 32'h1 : t[31:0];
  endfunction : at_least1

  //////////////////////////////////////////////////////////////////////////////
  state_t state_ff;
  cmd_req_t req_ff;
  logic [31:0] p1_ff;
  logic [31:0] w2;
  logic [6:0] mem_raddr;
  logic [31:0] mem_rdata;
  logic host_rvalid_ff;
  logic [PW-1:0] pre_ff;
  logic [4:0] ticks;
  chan_cfg_t cfg_ff [NUM_CH];
  logic [NUM_CH-1:0] load_ff;
  logic [NUM_CH-1:0] wave;
  status_t cmd_status_ff;
  logic cmd_status_valid_ff;
  status_t chan_status_ff;
  logic chan_status_valid_ff;
  logic irq_ff;
  logic eval;
  logic [4:0] ch;
  logic partner_busy;
  logic [33:0] per_u;
  logic [33:0] pw_u;
  logic [2:0] base;
  logic per_bad;
  logic pw_bad;
  logic [7:0] nxt_code;
  logic nxt_chan_report;
  chan_cfg_t nxt_cfg;
  chan_cfg_t nxt_pair;
  logic nxt_pair_we;

  assign eval = (state_ff == S_EVAL);
  assign ch = req_ff.chan;
  assign w2 = mem_rdata;
  assign partner_busy = (32'(ch) + 1 < NUM_CH) && (cfg_ff[5'(ch + 5'h1)].mode != M_OFF);

  //////////////////////////////////////////////////////////////////////////////
  // command sequencer: fetch both parameter words, then decide
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_ff <= S_IDLE;
    end else begin
      case (state_ff)
        S_IDLE: state_ff <= cmd_valid_in ? S_RD1 : S_IDLE;
        S_RD1: state_ff <= S_RD2;
        S_RD2: state_ff <= S_EVAL;
        S_EVAL: state_ff <= S_IDLE;
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      req_ff <= '0;
    end else if (state_ff == S_IDLE && cmd_valid_in) begin
      req_ff <= cmd_in;
    end
  end

  always_comb begin
    case (state_ff)
      S_RD1: mem_raddr = {ch, 2'(`CCB_PARAM1_OFF >> 2)};
      S_RD2: mem_raddr = {ch, 2'(`CCB_PARAM2_OFF >> 2)};
      default: mem_raddr = host_addr_in[8:2];
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      p1_ff <= 32'h0;
    end else if (state_ff == S_RD2) begin
      p1_ff <= mem_rdata;
    end
  end

  // host reads wait while the sequencer owns the read port
  assign host_ready_out = (state_ff == S_IDLE);
  assign cmd_ready_out = (state_ff == S_IDLE);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      host_rvalid_ff <= 1'b0;
    end else begin
      host_rvalid_ff <= host_re_in && (state_ff == S_IDLE);
    end
  end

  assign host_rvalid_out = host_rvalid_ff;
  assign host_rdata_out = mem_rdata;

  ccb_mem #(.AW(7)) u_ccb (
    .clk_in(clk_in),
    .we_in(host_we_in),
    .waddr_in(host_addr_in[8:2]),
    .wdata_in(host_wdata_in),
    .raddr_in(mem_raddr),
    .rdata_out(mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // command evaluation
  assign per_u = to_units(p1_ff);
  assign pw_u = to_units(w2);
  assign per_bad = (per_u < `NS_TO_UNITS(`PER_MIN_NS)) || (per_u > `US_TO_UNITS(`PER_MAX_US));
  assign pw_bad = (pw_u < `NS_TO_UNITS(`PW_MIN_NS)) || (pw_u > `US_TO_UNITS(`PW_MAX_US));
  assign base = tb_pick(per_u);

  always_comb begin
    nxt_code = `ST_ACK;
    nxt_chan_report = 1'b0;
    nxt_cfg = cfg_ff[ch];
    nxt_pair = '0;
    nxt_pair_we = 1'b0;
    if (32'(ch) >= NUM_CH) begin
      nxt_code = `ST_ALLOC;
    end else begin
      case (req_ff.code)
        `CMD_DISABLE: begin
          // only a disable stops a channel
          nxt_cfg = '0;
          nxt_pair_we = (cfg_ff[ch].mode != M_SLAVE) && partner_busy && (cfg_ff[5'(ch + 5'h1)].mode == M_SLAVE);
        end
        `CMD_DIV16: begin
          if (p1_ff[15:0] < 16'(`DIV16_MIN)) begin
            nxt_code = `ST_BOUNDS;
            nxt_chan_report = 1'b1;
          end else begin
            // divisor from the low half of word one
            nxt_cfg = '{M_EXT, 3'h0, 32'(p1_ff[15:0] - (p1_ff[15:0] >> 1)), 32'(p1_ff[15:0] >> 1)};
          end
        end
        `CMD_DIV32: begin
          if (ch[0] || 32'(ch) + 1 >= NUM_CH) begin
            nxt_code = `ST_ALLOC;
          end else if (partner_busy) begin
            nxt_code = `ST_ACTIVE;
          end else if (p1_ff <= `DIV32_LIMIT) begin
            nxt_code = `ST_BOUNDS;
          end else begin
            // count on even, drive on odd
            nxt_cfg = '{M_EXT, 3'h0, p1_ff - (p1_ff >> 1), p1_ff >> 1};
            nxt_pair = '{M_SLAVE, 3'h0, 32'h0, 32'h0};
            nxt_pair_we = 1'b1;
            nxt_code = `ST_DIV_READY;
          end
        end
        `CMD_SQUARE, `CMD_PULSE: begin
          if (per_bad || (req_ff.code == `CMD_PULSE && pw_bad)) begin
            nxt_code = `ST_BOUNDS;
          end else if (req_ff.code == `CMD_SQUARE) begin
            nxt_cfg.mode = M_TICK;
            nxt_cfg.base = base;
            nxt_cfg.hi = at_least1((per_u >> (`TB_STEP_LOG2 * base)) >> 1);
            nxt_cfg.lo = at_least1((per_u >> (`TB_STEP_LOG2 * base)) - (34'(nxt_cfg.hi)));
          end else if (pw_u > per_u) begin
            nxt_code = `ST_PERIOD;
            nxt_cfg = '{M_TICK, 3'h0, `ERR_HALF_UNITS, `ERR_HALF_UNITS};
          end else begin
            // high for width, low for the rest
            nxt_cfg.mode = M_TICK;
            nxt_cfg.base = base;
            nxt_cfg.hi = at_least1(pw_u >> (`TB_STEP_LOG2 * base));
            nxt_cfg.lo = at_least1((per_u - pw_u) >> (`TB_STEP_LOG2 * base));
          end
        end
        default: nxt_code = `ST_BAD_CMD;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cfg_ff[i] <= '0;
      end
      load_ff <= '0;
    end else begin
      load_ff <= '0;
      if (eval && 32'(ch) < NUM_CH) begin
        cfg_ff[ch] <= nxt_cfg;
        load_ff[ch] <= 1'b1;
        if (nxt_pair_we) begin
          cfg_ff[5'(ch + 5'h1)] <= nxt_pair;
          load_ff[5'(ch + 5'h1)] <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status posting
  // distinct codes per outcome
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cmd_status_ff <= '0;
      cmd_status_valid_ff <= 1'b0;
    end else begin
      cmd_status_valid_ff <= eval;
      if (eval) begin
        cmd_status_ff <= '{nxt_code, ch};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      chan_status_ff <= '0;
      chan_status_valid_ff <= 1'b0;
    end else begin
      chan_status_valid_ff <= eval && nxt_chan_report;
      if (eval && nxt_chan_report) begin
        chan_status_ff <= '{nxt_code, ch};
      end
    end
  end

  // interrupt only when enabled with a level
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= eval && irq_enable_in && (irq_level_in != 3'h0);
    end
  end

  assign cmd_status_out = cmd_status_ff;
  assign cmd_status_valid_out = cmd_status_valid_ff;
  assign chan_status_out = chan_status_ff;
  assign chan_status_valid_out = chan_status_valid_ff;
  assign cmd_irq_out = irq_ff;

  //////////////////////////////////////////////////////////////////////////////
  // time bases: 200 ns and each step sixteen times slower
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  for (genvar k = 0; k < `TB_COUNT; k++) begin : g_tick
    assign ticks[k] = &pre_ff[`TB0_LOG2 + `TB_STEP_LOG2 * k - 1:0];
  end

  // odd output is wired back to even gate by the user, gate not needed here
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    chan_counter u_cnt (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .load_in(load_ff[c]),
      .cfg_in(cfg_ff[c]),
      .ext_in(chan_clk_in[c]),
      .ticks_in(ticks),
      .wave_out(wave[c])
    );
    // odd pin carries the even counter in a pair
    if (c % 2 == 1) begin : g_odd
      assign chan_wave_out[c] = (cfg_ff[c].mode == M_SLAVE) ? wave[c - 1] : wave[c];
    end else begin : g_even
      assign chan_wave_out[c] = (cfg_ff[c + 1].mode == M_SLAVE) ? 1'b0 : wave[c];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  div16_bounds_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (eval && 32'(ch) < NUM_CH && req_ff.code == `CMD_DIV16 && p1_ff[15:0] < 16'h0002)
    |=> (chan_status_valid_ff && chan_status_ff.code == `ST_BOUNDS))
    else $error("small 16-bit divisor not refused");

  alloc_err_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (eval && req_ff.code == `CMD_DIV32 && ch[0]) |=> (cmd_status_ff.code == `ST_ALLOC))
    else $error("odd channel 32-bit divide not refused");

  active_err_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (eval && req_ff.code == `CMD_DIV32 && !ch[0] && partner_busy && 32'(ch) + 1 < NUM_CH)
    |=> (cmd_status_ff.code == `ST_ACTIVE) ##0 $stable(cfg_ff[ch]))
    else $error("busy partner not refused");

  div32_bounds_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (eval && req_ff.code == `CMD_DIV32 && !ch[0] && !partner_busy && 32'(ch) + 1 < NUM_CH
     && p1_ff <= 32'h0001_0000) |=> (cmd_status_ff.code == `ST_BOUNDS))
    else $error("small 32-bit divisor not refused");

  ready_irq_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmd_irq_out |-> (cmd_status_valid_out && $past(irq_enable_in) && $past(irq_level_in) != 3'h0))
    else $error("interrupt without enable or level");

  period_bounds_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (eval && 32'(ch) < NUM_CH && (req_ff.code == `CMD_SQUARE || req_ff.code == `CMD_PULSE) && (per_u < 34'h2))
    |=> (cmd_status_ff.code == `ST_BOUNDS))
    else $error("short period not refused");

  width_bounds_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (eval && 32'(ch) < NUM_CH && req_ff.code == `CMD_PULSE && !per_bad && pw_u == 34'h0)
    |=> (cmd_status_ff.code == `ST_BOUNDS))
    else $error("zero width not refused");

  period_err_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (eval && 32'(ch) < NUM_CH && req_ff.code == `CMD_PULSE && !per_bad && !pw_bad && pw_u > per_u)
    |=> (cmd_status_ff.code == `ST_PERIOD && cfg_ff[$past(ch)].hi == 32'h0000_80E8))
    else $error("period error wave not set");

  keep_running_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cfg_ff[1].mode != M_OFF && !eval) |=> (cfg_ff[1].mode == $past(cfg_ff[1].mode)))
    else $error("channel stopped without command");
endmodule : wave_gen

// [tb/host_model.sv]
// host side model of the channel control block and command ports
module host_model (
  // clock
  input wire logic clk_in,
  // memory port
  input wire logic ready_in,
  input wire logic [31:0] rdata_in,
  input wire logic rvalid_in,
  output logic we_out,
  output logic re_out,
  output logic [8:0] addr_out,
  output logic [31:0] wdata_out,
  // command port
  input wire logic cmd_ready_in,
  input cwg_pkg::status_t st_in,
  input wire logic st_valid_in,
  input wire logic irq_in,
  output logic cmd_valid_out,
  output cwg_pkg::cmd_req_t cmd_out,
  output logic irq_en_out,
  output logic [2:0] irq_lvl_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import cwg_pkg::*;
  initial begin
    {we_out, re_out, cmd_valid_out, irq_en_out} = 4'h0;
    {addr_out, wdata_out, cmd_out, irq_lvl_out} = '0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // parameters before command
  task automatic write_word(input logic [4:0] ch, input logic [3:0] off, input logic [31:0] d);
    @(posedge clk_in);
    we_out <= 1'b1;
    addr_out <= {ch, off};
    wdata_out <= d;
    @(posedge clk_in);
    we_out <= 1'b0;
    // released data shows the inverse so stale values never match
    wdata_out <= ~d;
  endtask : write_word
  task automatic read_word(input logic [4:0] ch, input logic [3:0] off, output logic [31:0] d, output logic ok);
    logic rdy;
    rdy = 1'b0;
    @(posedge clk_in);
    re_out <= 1'b1;
    addr_out <= {ch, off};
    for (int i = 0; i < 50 && !rdy; i++) begin
      @(negedge clk_in);
      rdy = (ready_in === 1'b1);
      @(posedge clk_in);
    end
    re_out <= 1'b0;
    @(negedge clk_in);
    ok = rdy && (rvalid_in === 1'b1);
    d = rdata_in;
  endtask : read_word
  task automatic send_cmd(input logic [7:0] code, input logic [4:0] ch, input logic en, input logic [2:0] lvl,
      output status_t st, output logic irq, output logic ok);
    logic rdy;
    {rdy, ok, irq} = 3'h0;
    st = '0;
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_out <= {code, ch};
    irq_en_out <= en;
    irq_lvl_out <= lvl;
    for (int i = 0; i < 50 && !rdy; i++) begin
      @(negedge clk_in);
      rdy = (cmd_ready_in === 1'b1);
      @(posedge clk_in);
    end
    cmd_valid_out <= 1'b0;
    cmd_out <= ~{code, ch};
    for (int i = 0; i < 20 && !ok; i++) begin
      @(negedge clk_in);
      if (st_valid_in === 1'b1) begin
        ok = rdy;
        st = st_in;
        irq = irq_in;
      end
    end
  endtask : send_cmd
endmodule : host_model

// [tb/wave_gen_tb_top.sv]
// self-checking bench of the waveform generator channels
`include "cwg_defs.svh"
module wave_gen_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cwg_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic we, re, rvalid, rdy, cv, crdy, ien, csv, chsv, irq;
  logic [8:0] addr;
  logic [31:0] wdata, rdata;
  logic [2:0] ilvl;
  cmd_req_t cmd;
  status_t cst, chst;
  logic [23:0] cclk = '0;
  logic [23:0] wave;
  int failures = 0;
  int check_count = 0;
  always #25 clk_in = ~clk_in;
  wave_gen #(.NUM_CH(24)) wave_gen_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .host_we_in(we), .host_re_in(re),
    .host_addr_in(addr), .host_wdata_in(wdata), .host_ready_out(rdy), .host_rdata_out(rdata),
    .host_rvalid_out(rvalid), .cmd_valid_in(cv), .cmd_in(cmd), .cmd_ready_out(crdy), .irq_enable_in(ien),
    .irq_level_in(ilvl), .cmd_status_out(cst), .cmd_status_valid_out(csv), .chan_status_out(chst),
    .chan_status_valid_out(chsv), .cmd_irq_out(irq), .chan_clk_in(cclk), .chan_wave_out(wave));
  host_model host_model_i (.clk_in(clk_in), .ready_in(rdy), .rdata_in(rdata), .rvalid_in(rvalid), .we_out(we),
    .re_out(re), .addr_out(addr), .wdata_out(wdata), .cmd_ready_in(crdy), .st_in(cst), .st_valid_in(csv),
    .irq_in(irq), .cmd_valid_out(cv), .cmd_out(cmd), .irq_en_out(ien), .irq_lvl_out(ilvl));
  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task automatic stall(input string what);
    failures++;
    $display("CHECK FAILED at %0t: %s", $time, what);
    complete_run();
  endtask : stall
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_word
  task automatic check_status(input status_t got, input logic [7:0] code, input logic [4:0] ch);
    check_count++;
    if (got !== {code, ch}) begin
      failures++;
      $display("CHECK FAILED at %0t: status %h exp %h", $time, got, {code, ch});
    end
  endtask : check_status
  task automatic do_cmd(input logic [7:0] code, input int ch, input logic en, input logic [2:0] lvl,
      input logic [7:0] exp, output logic q);
    status_t st;
    logic ok;
    host_model_i.send_cmd(code, 5'(ch), en, lvl, st, q, ok);
    if (!ok) stall("no command status");
    check_status(st, exp, 5'(ch));
  endtask : do_cmd
  task automatic wr(input int ch, input logic [3:0] off, input logic [31:0] d);
    host_model_i.write_word(5'(ch), off, d);
  endtask : wr
  // sampling once per input cycle makes the high count independent of phase
  task automatic pulses(input int ch, input int n, output int highs);
    highs = 0;
    repeat (n) begin
      @(posedge clk_in);
      cclk[ch] <= 1'b1;
      repeat (2) @(posedge clk_in);
      cclk[ch] <= 1'b0;
      @(posedge clk_in);
      @(negedge clk_in);
      if (wave[ch] === 1'b1) highs++;
    end
  endtask : pulses
  task automatic run_len(input int ch, input logic lvl, output int n);
    int k;
    n = 0;
    k = 0;
    while (k < 400 && wave[ch] === lvl) begin @(negedge clk_in); k++; end
    while (k < 400 && wave[ch] !== lvl) begin @(negedge clk_in); k++; end
    while (n < 400 && wave[ch] === lvl) begin @(negedge clk_in); n++; end
    if (k >= 400) stall("wave edge missing");
  endtask : run_len
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_readback();
    logic [31:0] d;
    logic ok;
    wr(5, `CCB_PARAM1_OFF, 32'hA5A5_0F0F);
    wr(5, `CCB_PARAM2_OFF, 32'h1234_5678);
    host_model_i.read_word(5'h5, `CCB_PARAM2_OFF, d, ok);
    if (!ok) stall("read not answered");
    check_word(d, 32'h1234_5678, "word at 8");
    host_model_i.read_word(5'h5, `CCB_PARAM1_OFF, d, ok);
    check_word(d, 32'hA5A5_0F0F, "word at 4");
  endtask : t_readback
  task automatic t_div16();
    int h;
    logic q;
    wr(0, `CCB_PARAM1_OFF, 32'h1);
    do_cmd(`CMD_DIV16, 0, 1'b0, 3'h0, `ST_BOUNDS, q);
    check_word(32'(chsv), 32'h1, "channel status pulse");
    check_status(chst, `ST_BOUNDS, 5'h0);
    // upper half of the word is not part of the 16-bit divisor
    wr(1, `CCB_PARAM1_OFF, 32'hFFFF_0004);
    do_cmd(`CMD_DIV16, 1, 1'b0, 3'h0, `ST_ACK, q);
    pulses(1, 16, h);
    check_word(32'(h), 32'h8, "div16 high samples");
    do_cmd(`CMD_DISABLE, 1, 1'b0, 3'h0, `ST_ACK, q);
    pulses(1, 8, h);
    check_word(32'(h), 32'h0, "disabled wave");
  endtask : t_div16
  task automatic t_div32();
    int h;
    logic q;
    do_cmd(`CMD_DIV32, 3, 1'b0, 3'h0, `ST_ALLOC, q);
    do_cmd(`CMD_DIV32, 24, 1'b0, 3'h0, `ST_ALLOC, q);
    wr(3, `CCB_PARAM1_OFF, 32'h4);
    do_cmd(`CMD_DIV16, 3, 1'b0, 3'h0, `ST_ACK, q);
    wr(2, `CCB_PARAM1_OFF, 32'h1_0001);
    do_cmd(`CMD_DIV32, 2, 1'b0, 3'h0, `ST_ACTIVE, q);
    do_cmd(`CMD_DISABLE, 3, 1'b0, 3'h0, `ST_ACK, q);
    wr(2, `CCB_PARAM1_OFF, 32'h1_0000);
    do_cmd(`CMD_DIV32, 2, 1'b1, 3'h3, `ST_BOUNDS, q);
    wr(2, `CCB_PARAM1_OFF, 32'h1_0001);
    do_cmd(`CMD_DIV32, 2, 1'b1, 3'h3, `ST_DIV_READY, q);
    check_word(32'(q), 32'h1, "ready interrupt");
    pulses(2, 4, h);
    check_word(32'(h), 32'h0, "even pin idle");
    check_word(32'(wave[3]), 32'h1, "odd pin divided output");
    do_cmd(`CMD_DISABLE, 2, 1'b1, 3'h0, `ST_ACK, q);
    check_word(32'(q), 32'h0, "level zero interrupt");
  endtask : t_div32
  task automatic t_period();
    int n;
    logic q;
    wr(6, `CCB_PARAM1_OFF, 32'h3780_0000);
    wr(6, `CCB_PARAM2_OFF, 32'h3800_0000);
    do_cmd(`CMD_SQUARE, 6, 1'b0, 3'h0, `ST_ACK, q);
    // low run first: the load forces the wave high, so the first high run may be cut short
    run_len(6, 1'b0, n);
    check_word(32'(n), 32'h98, "square low");
    run_len(6, 1'b1, n);
    check_word(32'(n), 32'h98, "square high");
    wr(6, `CCB_PARAM2_OFF, 32'h3680_0000);
    do_cmd(`CMD_PULSE, 6, 1'b0, 3'h0, `ST_ACK, q);
    run_len(6, 1'b0, n);
    check_word(32'(n), 32'hE4, "pulse low");
    run_len(6, 1'b1, n);
    check_word(32'(n), 32'h4C, "pulse high");
    wr(6, `CCB_PARAM1_OFF, 32'h3480_0000);
    do_cmd(`CMD_PULSE, 6, 1'b0, 3'h0, `ST_BOUNDS, q);
    wr(6, `CCB_PARAM1_OFF, 32'h4400_0000);
    do_cmd(`CMD_SQUARE, 6, 1'b0, 3'h0, `ST_BOUNDS, q);
    wr(6, `CCB_PARAM1_OFF, 32'h3780_0000);
    wr(6, `CCB_PARAM2_OFF, 32'h3400_0000);
    do_cmd(`CMD_PULSE, 6, 1'b0, 3'h0, `ST_BOUNDS, q);
    wr(6, `CCB_PARAM2_OFF, 32'h3800_0000);
    do_cmd(`CMD_PULSE, 6, 1'b0, 3'h0, `ST_PERIOD, q);
    repeat (2) @(negedge clk_in);
    n = 0;
    while (n < 1000 && wave[6] === 1'b1) begin @(negedge clk_in); n++; end
    check_word(32'(n), 32'h3E8, "fallback high");
  endtask : t_period
  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_readback();
    t_div16();
    t_div32();
    t_period();
    complete_run();
  end
endmodule : wave_gen_tb_top
